// ---- mmc_top.sv ----
/*
 * Management-port and reduced-interface configuration block: register file with
 * clear/set/invert aliases, management clock generation and the serial read/write engine.
 * Assumes one 25 MHz clock, a plain register port with read data one cycle after the
 * strobe, and an external wire that resolves mdio from mdio_o and mdio_oe_n_o.
 */
// Local design decisions: the plain strobed port and the register addresses.
`default_nettype none
module mmc_top import mmc_pkg::*; (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [1:0] size_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic reduced_if_mode_i,
	output logic reduced_if_logic_reset_o,
	output logic reduced_if_speed_100_o,
	output logic mdc_o,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_n_o
);
	typedef struct packed {
		logic [31:0] rdata;
		logic reduced_if_logic_reset;
		logic reduced_if_speed_select;
		logic mgmt_engine_reset;
		logic [3:0] mgmt_clock_divider_select;
		logic preamble_suppress;
		logic scan_increment;
		logic [4:0] phy_address_limit;
		logic [4:0] reg_addr;
		logic [15:0] write_data;
		logic cmd_scan;
		logic read_req;
		logic write_req;
		logic [15:0] read_data;
		mmc_state_e state;
		logic is_write;
		logic [5:0] bit_cnt;
		logic [31:0] shreg;
		logic [4:0] cur_phy;
		logic mdio_out;
		logic mdio_oe_n;
		logic rif_rst_out;
		logic rif_spd_out;
	} mmc_top_s;

	mmc_top_s cur;
	mmc_top_s next_cur;
	logic mdc_int;
	logic mdc_rise;
	logic mdc_fall;
	logic mdio_s;
	logic rif_mode_s;
	logic div_rst;

	mmc_sync #(.WIDTH(2)) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i({mdio_i, reduced_if_mode_i}),
		.sync_o({mdio_s, rif_mode_s})
	);

	assign div_rst = sys_rst_i | cur.mgmt_engine_reset;

	mmc_clkdiv u_div (
		.clk_i(clk_i),
		.sys_rst_i(div_rst),
		.half_period_i(mmc_half_period(cur.mgmt_clock_divider_select)),
		.mdc_o(mdc_int),
		.rise_o(mdc_rise),
		.fall_o(mdc_fall)
	);

	// Apply a write through one of the four aliases
	function automatic logic [15:0] alias_apply(input logic [15:0] old, input logic [15:0] wd,
			input logic [1:0] sel);
		case (sel)
			ALIAS_CLR: alias_apply = old & ~wd;
			ALIAS_SET: alias_apply = old | wd;
			ALIAS_INV: alias_apply = old ^ wd;
			default: alias_apply = wd;
		endcase
	endfunction

	always_comb begin
		logic [7:0] base;
		logic [1:0] sel;
		logic access_ok;
		logic [15:0] old_v;
		logic [15:0] new_v;
		logic [15:0] stat_v;
		logic start;
		logic [4:0] first_phy;
		logic read_set;
		logic write_set;
		base = {addr_i[7:4], 4'h0};
		sel = addr_i[3:2];
		old_v = '0;
		new_v = '0;
		start = 1'b0;
		first_phy = '0;
		read_set = 1'b0;
		write_set = 1'b0;
		next_cur = cur;
		// Only 16-bit accesses to the low half and 32-bit accesses reach the registers
		access_ok = (size_i == SIZE_32) || (size_i == SIZE_16 && !addr_i[1]);

		stat_v = '0;
		stat_v[POS_STAT_BUSY] = (cur.state != MMC_IDLE);
		stat_v[POS_STAT_CUR_PHY_LSB +: 5] = cur.cur_phy;

		// Register read, data valid the cycle after the strobe
		next_cur.rdata = '0;
		if (rd_i && access_ok) begin
			case (addr_i[7:2])
				OFS_PHY_SUPPORT_CONTROL[7:2]: begin
					next_cur.rdata[POS_REDUCED_IF_LOGIC_RESET] = cur.reduced_if_logic_reset;
					next_cur.rdata[POS_REDUCED_IF_SPEED_SELECT] = cur.reduced_if_speed_select;
				end
				OFS_MGMT_PORT_CONFIG[7:2]: begin
					next_cur.rdata[POS_MGMT_ENGINE_RESET] = cur.mgmt_engine_reset;
					next_cur.rdata[POS_CLKSEL_LSB +: 4] = cur.mgmt_clock_divider_select;
					next_cur.rdata[POS_PREAMBLE_SUPPRESS] = cur.preamble_suppress;
					next_cur.rdata[POS_SCAN_INCREMENT] = cur.scan_increment;
				end
				OFS_MGMT_TARGET_ADDRESS[7:2]: begin
					next_cur.rdata[POS_PHY_LIMIT_LSB +: 5] = cur.phy_address_limit;
					next_cur.rdata[POS_REG_ADDR_LSB +: 5] = cur.reg_addr;
				end
				OFS_MGMT_COMMAND[7:2]: begin
					next_cur.rdata[POS_CMD_SCAN] = cur.cmd_scan;
					next_cur.rdata[POS_CMD_READ] = cur.read_req;
				end
				OFS_MGMT_WRITE_DATA[7:2]: next_cur.rdata[15:0] = cur.write_data;
				OFS_MGMT_STATUS[7:2]: next_cur.rdata[15:0] = stat_v;
				OFS_MGMT_READ_DATA[7:2]: next_cur.rdata[15:0] = cur.read_data;
				default: next_cur.rdata = '0;
			endcase
		end

		// Register write through the aliases; 8-bit writes change nothing
		if (wr_i && access_ok) begin
			case (base)
				OFS_PHY_SUPPORT_CONTROL: begin
					old_v = '0;
					old_v[POS_REDUCED_IF_LOGIC_RESET] = cur.reduced_if_logic_reset;
					old_v[POS_REDUCED_IF_SPEED_SELECT] = cur.reduced_if_speed_select;
					new_v = alias_apply(old_v, wdata_i[15:0], sel);
					next_cur.reduced_if_logic_reset = new_v[POS_REDUCED_IF_LOGIC_RESET];
					next_cur.reduced_if_speed_select = new_v[POS_REDUCED_IF_SPEED_SELECT];
				end
				OFS_MGMT_PORT_CONFIG: begin
					old_v = '0;
					old_v[POS_MGMT_ENGINE_RESET] = cur.mgmt_engine_reset;
					old_v[POS_CLKSEL_LSB +: 4] = cur.mgmt_clock_divider_select;
					old_v[POS_PREAMBLE_SUPPRESS] = cur.preamble_suppress;
					old_v[POS_SCAN_INCREMENT] = cur.scan_increment;
					new_v = alias_apply(old_v, wdata_i[15:0], sel);
					next_cur.mgmt_engine_reset = new_v[POS_MGMT_ENGINE_RESET];
					next_cur.mgmt_clock_divider_select = new_v[POS_CLKSEL_LSB +: 4];
					next_cur.preamble_suppress = new_v[POS_PREAMBLE_SUPPRESS];
					next_cur.scan_increment = new_v[POS_SCAN_INCREMENT];
				end
				OFS_MGMT_TARGET_ADDRESS: begin
					old_v = '0;
					old_v[POS_PHY_LIMIT_LSB +: 5] = cur.phy_address_limit;
					old_v[POS_REG_ADDR_LSB +: 5] = cur.reg_addr;
					new_v = alias_apply(old_v, wdata_i[15:0], sel);
					next_cur.phy_address_limit = new_v[POS_PHY_LIMIT_LSB +: 5];
					next_cur.reg_addr = new_v[POS_REG_ADDR_LSB +: 5];
				end
				OFS_MGMT_COMMAND: begin
					old_v = '0;
					old_v[POS_CMD_SCAN] = cur.cmd_scan;
					new_v = alias_apply(old_v, wdata_i[15:0], sel);
					next_cur.cmd_scan = new_v[POS_CMD_SCAN];
					if (new_v[POS_CMD_READ]) begin
						next_cur.read_req = 1'b1;
						read_set = 1'b1;
					end
				end
				OFS_MGMT_WRITE_DATA: begin
					next_cur.write_data = alias_apply(cur.write_data, wdata_i[15:0], sel);
					next_cur.write_req = 1'b1;
					write_set = 1'b1;
				end
				default: next_cur.write_data = cur.write_data;
			endcase
		end

		// Serial management engine
		first_phy = cur.scan_increment ? SCAN_FIRST_PHY : cur.phy_address_limit;
		case (cur.state)
			MMC_IDLE: begin
				if (cur.write_req || cur.read_req || cur.cmd_scan) begin
					next_cur.state = MMC_WAIT;
					next_cur.is_write = cur.write_req;
					next_cur.cur_phy = cur.write_req ? cur.phy_address_limit : first_phy;
				end
			end
			MMC_WAIT: begin
				if (mdc_fall) begin
					start = 1'b1;
				end
			end
			MMC_PRE: begin
				if (mdc_fall) begin
					if (cur.bit_cnt == 6'(PREAMBLE_BITS - 1)) begin
						next_cur.state = MMC_FRAME;
						next_cur.bit_cnt = '0;
					end else begin
						next_cur.bit_cnt = cur.bit_cnt + 6'd1;
					end
				end
			end
			MMC_FRAME: begin
				if (mdc_rise && !cur.is_write && cur.bit_cnt >= 6'(DATA_FIRST_BIT)) begin
					next_cur.read_data = {cur.read_data[14:0], mdio_s};
				end
				if (mdc_fall) begin
					next_cur.shreg = {cur.shreg[30:0], 1'b1};
					next_cur.bit_cnt = cur.bit_cnt + 6'd1;
					if (cur.bit_cnt == 6'(FRAME_BITS - 1)) begin
						next_cur.state = MMC_IDLE;
						if (cur.is_write) begin
							next_cur.write_req = 1'b0;
						end else begin
							next_cur.read_req = 1'b0;
							if (cur.cmd_scan && !cur.write_req) begin
								if (cur.scan_increment) begin
									// Wrap back to the first address after the limit
									next_cur.cur_phy = (cur.cur_phy >= cur.phy_address_limit) ?
										SCAN_FIRST_PHY : cur.cur_phy + 5'd1;
								end
								start = 1'b1;
							end
						end
					end
				end
			end
			default: next_cur.state = MMC_IDLE;
		endcase

		if (start) begin
			next_cur.bit_cnt = '0;
			next_cur.state = cur.preamble_suppress ? MMC_FRAME : MMC_PRE;
			next_cur.shreg = cur.is_write && cur.state == MMC_WAIT ?
				{FRAME_START, OP_WRITE, cur.cur_phy, cur.reg_addr, TA_WRITE, cur.write_data} :
				{FRAME_START, OP_READ, next_cur.cur_phy, cur.reg_addr, TA_READ, 16'hffff};
			if (cur.state == MMC_FRAME) begin
				next_cur.is_write = 1'b0;
			end
		end

		// A request written as a frame ends survives the frame's clear
		if (read_set) begin
			next_cur.read_req = 1'b1;
		end
		if (write_set) begin
			next_cur.write_req = 1'b1;
		end

		// Engine held idle while its reset bit is set
		if (cur.mgmt_engine_reset) begin
			next_cur.state = MMC_IDLE;
			next_cur.bit_cnt = '0;
			next_cur.read_req = 1'b0;
			next_cur.write_req = 1'b0;
		end

		// Pin drive registered from the next state
		next_cur.mdio_out = (next_cur.state == MMC_FRAME) ? next_cur.shreg[31] : 1'b1;
		next_cur.mdio_oe_n = !((next_cur.state == MMC_PRE) ||
			(next_cur.state == MMC_FRAME &&
			(next_cur.is_write || next_cur.bit_cnt < 6'(TA_FIRST_BIT))));

		next_cur.rif_rst_out = cur.reduced_if_logic_reset & rif_mode_s;
		next_cur.rif_spd_out = cur.reduced_if_speed_select & rif_mode_s;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cur <= '0;
			cur.state <= MMC_IDLE;
			cur.mgmt_clock_divider_select <= CLKSEL_RESET;
			cur.phy_address_limit <= PHY_LIMIT_RESET;
			cur.mdio_out <= 1'b1;
			cur.mdio_oe_n <= 1'b1;
			cur.shreg <= '1;
		end else begin
			cur <= next_cur;
		end
	end

	assign rdata_o = cur.rdata;
	assign reduced_if_logic_reset_o = cur.rif_rst_out;
	assign reduced_if_speed_100_o = cur.rif_spd_out;
	assign mdc_o = mdc_int;
	assign mdio_o = cur.mdio_out;
	assign mdio_oe_n_o = cur.mdio_oe_n;
endmodule // mmc_top
`default_nettype wire

// ---- mmc_pkg.sv ----
/*
 * Shared constants for the management-port and reduced-interface configuration block:
 * register offsets, field positions, reset values, engine states and the clock divider table.
 * Assumes a single 25 MHz system clock and a synchronous, active-high reset.
 */
`default_nettype none
package mmc_pkg;
	// Register byte offsets; each writable register owns a 16-byte slot for its aliases; status and read data share the 8'h50 slot
	localparam logic [7:0] OFS_PHY_SUPPORT_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MGMT_PORT_CONFIG = 8'h10;
	localparam logic [7:0] OFS_MGMT_TARGET_ADDRESS = 8'h20;
	localparam logic [7:0] OFS_MGMT_COMMAND = 8'h30;
	localparam logic [7:0] OFS_MGMT_WRITE_DATA = 8'h40;
	localparam logic [7:0] OFS_MGMT_STATUS = 8'h50;
	localparam logic [7:0] OFS_MGMT_READ_DATA = 8'h54;

	// Alias selector in address bits 3:2
	localparam logic [1:0] ALIAS_WRITE = 2'h0;
	localparam logic [1:0] ALIAS_CLR = 2'h1;
	localparam logic [1:0] ALIAS_SET = 2'h2;
	localparam logic [1:0] ALIAS_INV = 2'h3;

	// Access size codes
	localparam logic [1:0] SIZE_8 = 2'h0;
	localparam logic [1:0] SIZE_16 = 2'h1;
	localparam logic [1:0] SIZE_32 = 2'h2;

	// Field positions
	localparam int POS_REDUCED_IF_LOGIC_RESET = 11;
	localparam int POS_REDUCED_IF_SPEED_SELECT = 8;
	localparam int POS_MGMT_ENGINE_RESET = 15;
	localparam int POS_CLKSEL_LSB = 2;
	localparam int POS_PREAMBLE_SUPPRESS = 1;
	localparam int POS_SCAN_INCREMENT = 0;
	localparam int POS_PHY_LIMIT_LSB = 8;
	localparam int POS_REG_ADDR_LSB = 0;
	localparam int POS_CMD_SCAN = 1;
	localparam int POS_CMD_READ = 0;
	localparam int POS_STAT_BUSY = 0;
	localparam int POS_STAT_CUR_PHY_LSB = 8;

	// Reset values
	localparam logic [3:0] CLKSEL_RESET = 4'h8;
	localparam logic [4:0] PHY_LIMIT_RESET = 5'h01;

	// Management frame layout
	localparam int PREAMBLE_BITS = 32;
	localparam int FRAME_BITS = 32;
	localparam int TA_FIRST_BIT = 14;
	localparam int DATA_FIRST_BIT = 16;
	localparam logic [1:0] FRAME_START = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] TA_WRITE = 2'h2;
	localparam logic [1:0] TA_READ = 2'h3;
	localparam logic [4:0] SCAN_FIRST_PHY = 5'h01;

	typedef enum logic [1:0] {
		MMC_IDLE = 2'b00,
		MMC_WAIT = 2'b01,
		MMC_PRE = 2'b10,
		MMC_FRAME = 2'b11
	} mmc_state_e;

	// Half period of the management clock in system clocks for a select code
	function automatic logic [4:0] mmc_half_period(input logic [3:0] code);
		case (code)
			4'h0, 4'h1: mmc_half_period = 5'd2;
			4'h2: mmc_half_period = 5'd3;
			4'h3: mmc_half_period = 5'd4;
			4'h4: mmc_half_period = 5'd5;
			4'h5: mmc_half_period = 5'd7;
			4'h6: mmc_half_period = 5'd10;
			4'h7: mmc_half_period = 5'd14;
			4'h8: mmc_half_period = 5'd20;
			default: mmc_half_period = 5'd20;
		endcase
	endfunction
endpackage
`default_nettype wire

// ---- mmc_sync.sv ----
/*
 * Two-stage synchroniser for inputs from outside the system clock domain.
 * Assumes the inputs are slow levels; no event may be shorter than two clocks.
 */
`default_nettype none
module mmc_sync import mmc_pkg::*; #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} mmc_sync_s;

	mmc_sync_s cur;
	mmc_sync_s next_cur;

	always_comb begin
		next_cur.first = async_i;
		next_cur.second = cur.first;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign sync_o = cur.second;
endmodule // mmc_sync
`default_nettype wire

// ---- mmc_clkdiv.sv ----
/*
 * Management clock divider: toggles the clock every half period and marks each edge
 * with a one-cycle enable pulse. Assumes the half period is at least two system clocks.
 */
`default_nettype none
module mmc_clkdiv import mmc_pkg::*; (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [4:0] half_period_i,
	output logic mdc_o,
	output logic rise_o,
	output logic fall_o
);
	typedef struct packed {
		logic [4:0] cnt;
		logic mdc;
		logic rise;
		logic fall;
	} mmc_clkdiv_s;

	mmc_clkdiv_s cur;
	mmc_clkdiv_s next_cur;

	always_comb begin
		next_cur = cur;
		next_cur.rise = 1'b0;
		next_cur.fall = 1'b0;
		if (cur.cnt >= half_period_i - 5'd1) begin
			next_cur.cnt = '0;
			next_cur.mdc = ~cur.mdc;
			next_cur.rise = ~cur.mdc;
			next_cur.fall = cur.mdc;
		end else begin
			next_cur.cnt = cur.cnt + 5'd1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign mdc_o = cur.mdc;
	assign rise_o = cur.rise;
	assign fall_o = cur.fall;
endmodule // mmc_clkdiv
`default_nettype wire

// ---- mmc_top_properties.sv ----
/* Port-level checker for mmc_top.
 * Assumes it is bound to mmc_top from the bench top file. */
`default_nettype none
module mmc_top_properties import mmc_pkg::*; (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [1:0] size_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic reduced_if_mode_i,
	input wire logic reduced_if_logic_reset_o,
	input wire logic reduced_if_speed_100_o,
	input wire logic mdc_o,
	input wire logic mdio_i,
	input wire logic mdio_o,
	input wire logic mdio_oe_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_mode_low;
		!reduced_if_mode_i [*4];
	endsequence
	sequence s_byte_read;
		$past(rd_i) && $past(size_i) == SIZE_8;
	endsequence
	chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside read slot");
	chk_byte_read_zero: assert property (s_byte_read |-> rdata_o == 32'h0)
		else $error("byte read returned data");
	chk_upper_zero: assert property ($past(rd_i) |-> rdata_o[31:16] == 16'h0)
		else $error("upper read bits not zero");
	chk_rif_mode_off: assert property (s_mode_low |->
		!reduced_if_logic_reset_o && !reduced_if_speed_100_o)
		else $error("reduced outputs active in full mode");
	chk_rif_reset_src: assert property ($rose(reduced_if_logic_reset_o) |->
		$past(reduced_if_mode_i, 3))
		else $error("reduced reset rose without mode");
	chk_rif_speed_src: assert property ($rose(reduced_if_speed_100_o) |->
		$past(reduced_if_mode_i, 3))
		else $error("reduced speed rose without mode");
	chk_mdc_high_bound: assert property ($rose(mdc_o) |-> ##[1:20] !mdc_o)
		else $error("mdc high too long");
	chk_mdio_on_low: assert property ($changed(mdio_o) |-> !mdc_o)
		else $error("mdio changed while mdc high");
	chk_oe_on_low: assert property ($changed(mdio_oe_n_o) |-> !mdc_o)
		else $error("mdio enable changed while mdc high");
endmodule // mmc_top_properties
`default_nettype wire

// ---- mmc_phy_model.sv ----
/* Management-link PHY model: records each driven frame, answers reads.
 * Assumes a pulled-up data wire resolved by the bench. */
`default_nettype none
module mmc_phy_model import mmc_pkg::*; (
	input wire logic clk_i,
	input wire logic mdc_i,
	input wire logic mdio_i,
	input wire logic oe_n_i,
	output logic mdio_o,
	output logic done_o,
	output logic [6:0] len_o,
	output logic [31:0] frame_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic mdc_q = 1'b0, oe_q = 1'b1, answer = 1'b0;
	logic [6:0] cnt = '0;
	logic [5:0] idx = '0;
	logic [31:0] sr = '0;
	logic [15:0] reply = '0;
	initial begin
		mdio_o = 1'b1;
		done_o = 1'b0;
		len_o = '0;
		frame_o = '0;
	end
	always @(posedge clk_i) begin
		mdc_q <= mdc_i;
		oe_q <= oe_n_i;
		done_o <= 1'b0;
		if (mdc_i && !mdc_q && !oe_n_i) begin
			sr <= {sr[30:0], mdio_i};
			cnt <= cnt + 7'd1;
		end
		if (oe_n_i && !oe_q && cnt != 7'd0) begin
			done_o <= 1'b1;
			len_o <= cnt;
			frame_o <= sr;
			cnt <= '0;
			// Released after a read header: answer in the data phase
			answer <= sr[11:10] == OP_READ && cnt[4:0] == 5'd14;
			reply <= {8'hc3, 3'h0, sr[9:5]};
			idx <= 6'd15;
		end
		if (!mdc_i && mdc_q && answer) begin
			idx <= idx + 6'd1;
			if (idx == 6'd32) begin
				answer <= 1'b0;
				mdio_o <= 1'b1;
			end else if (idx == 6'd15) begin
				mdio_o <= 1'b0;
			end else begin
				mdio_o <= reply[15];
				reply <= {reply[14:0], 1'b0};
			end
		end
	end
endmodule // mmc_phy_model
`default_nettype wire

// ---- test_mii_mgmt_and_rmii_config.sv ----
/* Self-checking bench for mmc_top with a PHY model on the management link.
 * Assumes a pull-up on the data wire and a 25 MHz clock. */
`default_nettype none
module test_mii_mgmt_and_rmii_config import mmc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, reduced_if_mode_i = 0;
	logic [7:0] addr_i = '0;
	logic [31:0] wdata_i = '0, rdata_o, rd_d, frame;
	logic [1:0] size_i = SIZE_32;
	logic reduced_if_logic_reset_o, reduced_if_speed_100_o, mdc_o, mdio_o, mdio_oe_n_o;
	logic phy_mdio, done, mdio_w;
	logic [6:0] len;
	int errors = 0, n_compared = 0;
	assign mdio_w = mdio_oe_n_o ? phy_mdio : mdio_o;
	always #20 clk_i = ~clk_i;
	mmc_top i_mmc_top (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .size_i, .wr_i, .rd_i,
		.rdata_o, .reduced_if_mode_i, .reduced_if_logic_reset_o, .reduced_if_speed_100_o,
		.mdc_o, .mdio_i(mdio_w), .mdio_o, .mdio_oe_n_o);
	mmc_phy_model i_mmc_phy_model (.clk_i, .mdc_i(mdc_o), .mdio_i(mdio_w),
		.oe_n_i(mdio_oe_n_o), .mdio_o(phy_mdio), .done_o(done), .len_o(len), .frame_o(frame));
	task automatic check(input logic [31:0] got, exp, input string what);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] s = SIZE_32);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		size_i <= s;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] s = SIZE_32);
		@(posedge clk_i);
		addr_i <= a;
		size_i <= s;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 rd_d = rdata_o;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 3000; i++) begin
			rd(OFS_MGMT_STATUS);
			if (rd_d[POS_STAT_BUSY] === 1'b0) return;
		end
		check(1, 0, "busy stuck");
	endtask
	task automatic wait_frame();
		for (int i = 0; i < 6000; i++) begin
			@(posedge clk_i);
			if (done === 1'b1) return;
		end
		check(1, 0, "no frame");
	endtask
	task automatic t_regs();
		rd(OFS_PHY_SUPPORT_CONTROL);
		check(rd_d, 32'h0, "support reset");
		rd(OFS_MGMT_PORT_CONFIG);
		check(rd_d, 32'h20, "config reset");
		wr(8'h00, 32'h0900, SIZE_16);
		wr(8'h04, 32'h0100, SIZE_16);
		wr(8'h0c, 32'h0900);
		wr(8'h08, 32'h0800, SIZE_8);
		rd(8'h00);
		check(rd_d, 32'h0100, "alias result");
		wr(8'h08, 32'h0800, SIZE_16);
		wr(8'h02, 32'h0000, SIZE_16);
		rd(8'h00);
		check(rd_d, 32'h0900, "set alias, upper half refused");
		rd(8'h00, SIZE_8);
		check(rd_d, 32'h0, "byte read");
		rd(8'h60);
		check(rd_d, 32'h0, "unmapped read");
	endtask
	task automatic t_rif();
		logic [15:0] v [4] = '{16'h0900, 16'h0800, 16'h0100, 16'h0000};
		reduced_if_mode_i <= 1'b1;
		foreach (v[i]) begin
			wr(OFS_PHY_SUPPORT_CONTROL, {16'h0, v[i]});
			repeat (5) @(posedge clk_i);
			check(reduced_if_logic_reset_o, v[i][11], "reduced reset");
			check(reduced_if_speed_100_o, v[i][8], "reduced speed");
		end
		wr(OFS_PHY_SUPPORT_CONTROL, 32'h0900);
		reduced_if_mode_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		check({reduced_if_logic_reset_o, reduced_if_speed_100_o}, 0, "full mode");
	endtask
	task automatic t_div();
		logic [3:0] code [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 4'hf};
		int ratio [10] = '{4, 4, 6, 8, 10, 14, 20, 28, 40, 40};
		int n, k;
		logic m;
		wr(OFS_MGMT_TARGET_ADDRESS, 32'h0101);
		// Fastest code gives 6.25 MHz, inside the PHY limit
		foreach (code[i]) begin
			wr(OFS_MGMT_PORT_CONFIG, {26'h0, code[i], 2'b10});
			wr(OFS_MGMT_COMMAND, 32'h1);
			wait_frame();
			n = 0;
			k = 0;
			m = mdc_o;
			for (int c = 0; c < 200 && k < 2; c++) begin
				@(posedge clk_i);
				if (mdc_o && !m) k++;
				if (k == 1) n++;
				m = mdc_o;
			end
			check(n, ratio[i], "mdc period");
			wait_idle();
		end
	endtask
	task automatic t_frames();
		wr(OFS_MGMT_TARGET_ADDRESS, 32'h0503);
		for (int p = 0; p < 2; p++) begin
			wr(OFS_MGMT_PORT_CONFIG, 32'h20 | (p << 1));
			wr(OFS_MGMT_COMMAND, 32'h1);
			wait_frame();
			check(len, p ? 14 : 46, "driven read bits");
			check(frame[13:0], {FRAME_START, OP_READ, 5'd5, 5'd3}, "read header");
			wait_idle();
			rd(OFS_MGMT_READ_DATA);
			check(rd_d, 32'hc305, "read data");
		end
		wr(OFS_MGMT_WRITE_DATA, 32'hbeef);
		wait_frame();
		check(len, 32, "driven write bits");
		check(frame, {FRAME_START, OP_WRITE, 5'd5, 5'd3, TA_WRITE, 16'hbeef}, "write");
		wait_idle();
	endtask
	task automatic t_scan();
		logic [4:0] inc [5] = '{1, 2, 3, 1, 2};
		wr(OFS_MGMT_TARGET_ADDRESS, 32'h0300);
		for (int s = 0; s < 2; s++) begin
			wr(OFS_MGMT_PORT_CONFIG, s ? 32'h22 : 32'h23);
			wr(OFS_MGMT_COMMAND, 32'h2);
			foreach (inc[i]) begin
				wait_frame();
				check(frame[9:5], s ? 5'd3 : inc[i], "scan address");
			end
			wr(OFS_MGMT_COMMAND, 32'h0);
			wait_idle();
		end
	endtask
	task automatic t_engine();
		wr(OFS_MGMT_PORT_CONFIG, 32'h8022);
		wr(OFS_MGMT_COMMAND, 32'h1);
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk_i);
			if (done === 1'b1) check(1, 0, "frame in engine reset");
		end
		check(mdio_oe_n_o, 1, "engine released");
		check(mdc_o, 0, "mdc held in engine reset");
		wr(OFS_MGMT_PORT_CONFIG, 32'h0022);
	endtask
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_rif();
		t_div();
		t_frames();
		t_scan();
		t_engine();
		end_of_test();
	end
	initial begin
		repeat (100000) @(posedge clk_i);
		errors++;
		end_of_test();
	end
endmodule // test_mii_mgmt_and_rmii_config
bind mmc_top mmc_top_properties i_mmc_top_properties (.clk_i, .sys_rst_i, .addr_i, .wdata_i,
	.size_i, .wr_i, .rd_i, .rdata_o, .reduced_if_mode_i, .reduced_if_logic_reset_o,
	.reduced_if_speed_100_o, .mdc_o, .mdio_i, .mdio_o, .mdio_oe_n_o);
`default_nettype wire
